// File: core/ssf_pkg.sv
/*
  Constants shared by the serial-port status flag block: register byte
  addresses, field positions, reset values and control bit positions.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
package ssf_pkg;

  // Register byte addresses
  localparam logic [7:0] SSF_OFF_STATUS   = 8'h94; // Read-only flags
  localparam logic [7:0] SSF_OFF_CTRL     = 8'h98; // Enable and mode
  localparam logic [7:0] SSF_OFF_IRQ_STAT = 8'h9c; // Sticky events, W1C
  localparam logic [7:0] SSF_OFF_IRQ_MASK = 8'ha0; // Event enables

  // Status register field positions
  localparam int SSF_ST_BF  = 0; // Buffer full
  localparam int SSF_ST_UA  = 1; // Address update needed
  localparam int SSF_ST_RW  = 2; // Read/write from last match
  localparam int SSF_ST_S   = 3; // Start seen last
  localparam int SSF_ST_P   = 4; // Stop seen last
  localparam int SSF_ST_DNA = 5; // Data, not address
  localparam int SSF_ST_W   = 8; // Status width

  // Control register field positions
  localparam int SSF_CT_EN   = 0; // Port enable control
  localparam int SSF_CT_MODE = 1; // 1 selects I2C, 0 selects SPI
  localparam int SSF_CT_TEN  = 2; // Ten-bit I2C addressing
  localparam int SSF_CT_W    = 3; // Control width

  // Interrupt event positions
  localparam int SSF_EV_START = 0; // Start condition seen
  localparam int SSF_EV_STOP  = 1; // Stop condition seen
  localparam int SSF_EV_BYTE  = 2; // Buffer became full
  localparam int SSF_EV_UA    = 3; // Address update requested
  localparam int SSF_EV_W     = 4; // Event count

  // Reset values
  localparam logic [SSF_ST_W-1:0] SSF_STATUS_RST = 8'h00;
  localparam logic [SSF_CT_W-1:0] SSF_CTRL_RST   = 3'h0;
  localparam logic [SSF_EV_W-1:0] SSF_IRQ_RST    = 4'h0;

  // Port mode encoding
  typedef enum logic {
    SSF_MODE_SPI = 1'b0,
    SSF_MODE_I2C = 1'b1
  } ssf_mode_e;

endpackage

// File: core/ssf_flag_if.sv
/*
  Carrier between the top and the flag keeper: control levels and
  engine event strobes in, status byte and event pulses out.
  Assumes all signals live on core_clk.
*/
`timescale 1ns/1ps
interface ssf_flag_if;
  import ssf_pkg::*;
  logic                en;        // Port enable control
  ssf_mode_e           mode;      // SPI or I2C
  logic                ten_bit;   // Ten-bit addressing
  logic                start_det; // Start condition strobe
  logic                stop_det;  // Stop condition strobe
  logic                addr_done; // Address byte finished
  logic                data_done; // Data byte finished
  logic                match;     // Address matched
  logic                match_rw;  // R/W bit after the match
  logic                rx_done;   // Received byte complete
  logic                tx_load;   // Transmit started
  logic                tx_done;   // Transmit finished
  logic                buf_read;  // Buffer read by software
  logic                ua_req;    // Next address byte needed
  logic                ua_clr;    // Address register written
  logic [SSF_ST_W-1:0] status;    // Assembled status byte
  logic [SSF_EV_W-1:0] events;    // One-cycle event pulses

  modport keeper (input en, mode, ten_bit, start_det, stop_det,
                  addr_done, data_done, match, match_rw, rx_done,
                  tx_load, tx_done, buf_read, ua_req, ua_clr,
                  output status, events);
  modport top    (output en, mode, ten_bit, start_det, stop_det,
                  addr_done, data_done, match, match_rw, rx_done,
                  tx_load, tx_done, buf_read, ua_req, ua_clr,
                  input status, events);
endinterface

// File: core/ssf_flag_keeper.sv
/*
  Keeps the status flags of the serial port and raises event pulses.
  Assumes engine strobes are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module ssf_flag_keeper
  import ssf_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  // Flag carrier
  ssf_flag_if.keeper  fi
);

  logic dna_q, dna_d;     // Data, not address
  logic p_q, p_d;         // Stop seen last
  logic s_q, s_d;         // Start seen last
  logic rw_q, rw_d;       // Direction of last match
  logic ua_q, ua_d;       // Address update needed
  logic bf_q, bf_d;       // Buffer full
  logic i2c;              // I2C mode active

  // Next flag values
  always_comb begin
    i2c  = fi.en && (fi.mode == SSF_MODE_I2C);
    dna_d = dna_q;
    p_d   = p_q;
    s_d   = s_q;
    rw_d  = rw_q;
    ua_d  = ua_q;
    bf_d  = bf_q;
    if (!i2c) begin
      // SPI mode or disabled: I2C-only flags read zero
      dna_d = 1'b0;
      rw_d  = 1'b0;
      ua_d  = 1'b0;
      p_d   = 1'b0;
      s_d   = 1'b0;
    end else begin
      // Last byte kind wins; data beats address if both strobe
      if (fi.addr_done) dna_d = 1'b0;
      if (fi.data_done) dna_d = 1'b1;
      // Most recent bus condition
      if (fi.stop_det) begin
        p_d = 1'b1;
        s_d = 1'b0;
      end else if (fi.start_det) begin
        s_d = 1'b1;
        p_d = 1'b0;
      end
      // Direction valid from match until next start or stop
      if (fi.start_det || fi.stop_det) rw_d = 1'b0;
      else if (fi.match) rw_d = fi.match_rw;
      // Set beats the software clear
      if (fi.ua_clr) ua_d = 1'b0;
      if (fi.ua_req && fi.ten_bit) ua_d = 1'b1;
    end
    // Clear first so a new fill in the same cycle wins
    if (fi.buf_read || (i2c && fi.tx_done)) bf_d = 1'b0;
    if (fi.rx_done || (i2c && fi.tx_load)) bf_d = 1'b1;
  end

  // Flag registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dna_d_reg_reset: begin
        dna_q <= 1'b0;
        p_q   <= 1'b0;
        s_q   <= 1'b0;
        rw_q  <= 1'b0;
        ua_q  <= 1'b0;
        bf_q  <= 1'b0;
      end
    end else if (ce) begin
      dna_q <= dna_d;
      p_q   <= p_d;
      s_q   <= s_d;
      rw_q  <= rw_d;
      ua_q  <= ua_d;
      bf_q  <= bf_d;
    end
  end

  // Status byte, top bits unimplemented
  always_comb begin
    fi.status             = SSF_STATUS_RST;
    fi.status[SSF_ST_DNA] = dna_q;
    fi.status[SSF_ST_P]   = p_q;
    fi.status[SSF_ST_S]   = s_q;
    fi.status[SSF_ST_RW]  = rw_q;
    fi.status[SSF_ST_UA]  = ua_q;
    fi.status[SSF_ST_BF]  = bf_q;
  end

  // Rising edges of the start, stop, buffer-full and address-update flags become interrupt events
  always_comb begin
    fi.events               = SSF_IRQ_RST;
    fi.events[SSF_EV_START] = s_d && !s_q;
    fi.events[SSF_EV_STOP]  = p_d && !p_q;
    fi.events[SSF_EV_BYTE]  = bf_d && !bf_q;
    fi.events[SSF_EV_UA]    = ua_d && !ua_q;
  end

endmodule

// File: core/ssf_irq_ctl.sv
/*
  Sticky interrupt status with write-one-to-clear, a mask and one level
  interrupt output. Assumes event pulses on core_clk.
*/
`timescale 1ns/1ps
module ssf_irq_ctl
  import ssf_pkg::*;
#(
  parameter int N = SSF_EV_W // Number of events
)(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Events and software access
  input  wire logic [N-1:0] ev,
  input  wire logic         clr_we,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] wdata,
  // Results
  output logic      [N-1:0] stat_q,
  output logic      [N-1:0] mask_q,
  output logic              irq_q
);

  logic [N-1:0] stat_d; // Next sticky bits
  logic [N-1:0] mask_d; // Next mask
  logic         irq_d;  // Next interrupt level

  // Per-event sticky bit; a new event beats a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_comb begin
        stat_d[g] = ev[g] || (stat_q[g] && !(clr_we && wdata[g]));
      end
    end
  endgenerate

  // Mask and interrupt level
  always_comb begin
    mask_d = mask_we ? wdata : mask_q;
    irq_d  = |(stat_d & mask_d);
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else if (ce) begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

endmodule

// File: core/ssf_status_top.sv
/*
  Top of the serial-port status flag block: Avalon-MM register slave,
  control register, flag keeper and interrupt control.
  Assumes the transfer engines run on core_clk and send one-cycle
  strobes; no pin is read here, so no synchroniser is needed.
*/
// Overview of operation
// - Port runs either SPI or I2C mode
// - Status bits seven and six read zero
// - I2C: data flag marks data versus address
// - I2C: stop flag shows stop seen last
// - I2C: start flag shows start seen last
// - Disabling port clears start and stop flags
// - I2C: direction held from match to condition
// - Buffer full while byte held, or while sending in I2C only
`timescale 1ns/1ps
module ssf_status_top
  import ssf_pkg::*;
#(
  parameter int ADDR_W = 8,  // Avalon byte address width
  parameter int DATA_W = 32  // Avalon data width
)(
  // Clock, reset and clock enable
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // Strobes from the transfer engines
  input  wire logic              start_det,
  input  wire logic              stop_det,
  input  wire logic              addr_byte_done,
  input  wire logic              data_byte_done,
  input  wire logic              addr_match,
  input  wire logic              match_rw,
  input  wire logic              rx_complete,
  input  wire logic              tx_load,
  input  wire logic              tx_done,
  input  wire logic              buffer_read,
  input  wire logic              addr_update_req,
  input  wire logic              addr_reg_written,
  // Control levels to the engines
  output logic                   port_enable_control,
  output logic                   i2c_mode,
  output logic                   ten_bit_mode,
  // Interrupt
  output logic                   irq
);

  // Refuse widths the decode and data mux cannot serve
  generate
    if (ADDR_W < 8 || DATA_W != 32) begin : g_bad_param
      $error("ssf_status_top: ADDR_W must be >= 8 and DATA_W 32");
    end
  endgenerate

  // Address match against a byte offset; upper address bits must be 0
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == ADDR_W'(off));
  endfunction

  // Bus answer state
  logic              wait_q, wait_d;   // Waitrequest register
  logic [DATA_W-1:0] rdata_q, rdata_d; // Read data register
  logic              req;              // Read or write pending
  logic              fire;             // Write completes this edge

  // Control register
  logic [SSF_CT_W-1:0] ctrl_q, ctrl_d; // Enable, mode, ten-bit

  // Interrupt control wiring
  logic [SSF_EV_W-1:0] ist;     // Sticky status
  logic [SSF_EV_W-1:0] imask;   // Mask
  logic                irq_w;   // Registered interrupt level
  logic                clr_we;  // Status clear strobe
  logic                mask_we; // Mask write strobe

  // Carrier to the flag keeper
  ssf_flag_if fi ();

  // Control levels and engine strobes onto the carrier
  always_comb begin
    fi.en        = ctrl_q[SSF_CT_EN];
    fi.mode      = ssf_mode_e'(ctrl_q[SSF_CT_MODE]);
    fi.ten_bit   = ctrl_q[SSF_CT_TEN];
    fi.start_det = start_det;
    fi.stop_det  = stop_det;
    fi.addr_done = addr_byte_done;
    fi.data_done = data_byte_done;
    fi.match     = addr_match;
    fi.match_rw  = match_rw;
    fi.rx_done   = rx_complete;
    fi.tx_load   = tx_load;
    fi.tx_done   = tx_done;
    fi.buf_read  = buffer_read;
    fi.ua_req    = addr_update_req;
    fi.ua_clr    = addr_reg_written;
  end

  // Flag keeper
  ssf_flag_keeper u_keeper (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .fi       (fi.keeper)
  );

  // Interrupt control
  ssf_irq_ctl #(
    .N        (SSF_EV_W)
  ) u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .ev       (fi.events),
    .clr_we   (clr_we),
    .mask_we  (mask_we),
    .wdata    (avs_writedata[SSF_EV_W-1:0]),
    .stat_q   (ist),
    .mask_q   (imask),
    .irq_q    (irq_w)
  );

  // Request and completion qualifiers
  always_comb begin
    req     = avs_read || avs_write;
    // A write lands only at the edge where waitrequest is seen low
    fire    = avs_write && !wait_q;
    clr_we  = fire && hit(avs_address, SSF_OFF_IRQ_STAT);
    mask_we = fire && hit(avs_address, SSF_OFF_IRQ_MASK);
  end

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (fire && hit(avs_address, SSF_OFF_CTRL)) begin
      // Clearing enable also wipes start and stop in the keeper
      ctrl_d = avs_writedata[SSF_CT_W-1:0];
    end
  end

  // Control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= SSF_CTRL_RST;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Bus answer: waitrequest drops for one cycle after a request.
  // The one-cycle wait costs a clock per access but lets read data
  // come straight from a flip-flop.
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = '0;
    if (req && wait_q) begin
      wait_d = 1'b0;
      if (avs_read) begin
        // Unmapped addresses read as zero
        if (hit(avs_address, SSF_OFF_STATUS)) begin
          rdata_d[SSF_ST_W-1:0] = fi.status;
        end else if (hit(avs_address, SSF_OFF_CTRL)) begin
          rdata_d[SSF_CT_W-1:0] = ctrl_q;
        end else if (hit(avs_address, SSF_OFF_IRQ_STAT)) begin
          rdata_d[SSF_EV_W-1:0] = ist;
        end else if (hit(avs_address, SSF_OFF_IRQ_MASK)) begin
          rdata_d[SSF_EV_W-1:0] = imask;
        end
      end
    end
  end

  // Bus answer registers; waitrequest high in reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else if (ce) begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs, all from flip-flops
  always_comb begin
    avs_waitrequest     = wait_q;
    avs_readdata        = rdata_q;
    port_enable_control = ctrl_q[SSF_CT_EN];
    i2c_mode            = ctrl_q[SSF_CT_MODE];
    ten_bit_mode        = ctrl_q[SSF_CT_TEN];
    irq                 = irq_w;
  end

endmodule

// File: testbench/ssf_eng_model.sv
/*
  Stand-in for the transfer engines: turns a request vector from the
  bench into one-cycle strobes. Assumes requests held for one cycle.
*/
`timescale 1ns/1ps
module ssf_eng_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Requests from the bench
  input  wire logic [10:0] req,
  input  wire logic        rw_in,
  // Strobes to the block
  output logic      [10:0] strb,
  output logic             rw_out
);
  // Strobes last one cycle; the R/W line flips when no match is
  // signalled, so a design that samples it late sees junk
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strb   <= '0;
      rw_out <= 1'b0;
    end else begin
      strb   <= req;
      rw_out <= req[4] ? rw_in : !rw_out;
    end
  end
endmodule

// File: testbench/ssf_status_chk.sv
/*
  Checker for the status block: bus handshake, status byte shape,
  control register and irq cause. Bound to the top, sees its ports.
*/
`timescale 1ns/1ps
module ssf_status_chk
  import ssf_pkg::*;
#(
  parameter int ADDR_W = 8,  // Bus address width
  parameter int DATA_W = 32  // Bus data width
)(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              ce,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Engine strobes
  input wire logic              start_det,
  input wire logic              stop_det,
  input wire logic              rx_complete,
  input wire logic              tx_load,
  input wire logic              addr_update_req,
  // Levels out
  input wire logic              port_enable_control,
  input wire logic              i2c_mode,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic st_rd;  // Status read answered
  logic wr_ct;  // Control write taking effect
  logic en_x;   // Enable bit last written
  logic md_x;   // Mode bit last written
  assign st_rd = avs_read && !avs_waitrequest
               && avs_address == ADDR_W'(SSF_OFF_STATUS);
  assign wr_ct = ce && avs_write && !avs_waitrequest
               && avs_address == ADDR_W'(SSF_OFF_CTRL);
  // Remember written control bits
  always_ff @(posedge core_clk) begin
    if (wr_ct) begin
      en_x <= avs_writedata[SSF_CT_EN];
      md_x <= avs_writedata[SSF_CT_MODE];
    end
  end
  a_wait_answer: assert property (ce && (avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == '0)
    else $error("read data outside answer");
  a_top_bits: assert property (st_rd |->
    avs_readdata[DATA_W-1:6] == '0) else $error("upper status bits set");
  a_last_cond: assert property (st_rd |->
    !(avs_readdata[SSF_ST_S] && avs_readdata[SSF_ST_P]))
    else $error("start and stop both set");
  a_off_clear: assert property ((!port_enable_control)[*4] ##0 st_rd
    |-> avs_readdata[5:1] == '0) else $error("flags kept while off");
  a_spi_clear: assert property ((!i2c_mode)[*4] ##0 st_rd
    |-> avs_readdata[5:1] == '0) else $error("i2c flags in spi mode");
  a_ctrl_copy: assert property (wr_ct |-> ##[1:2]
    (port_enable_control == en_x && i2c_mode == md_x))
    else $error("control not applied");
  a_irq_cause: assert property ($rose(irq) |-> $past(start_det
    || stop_det || rx_complete || tx_load || addr_update_req
    || avs_write)) else $error("irq without cause");
endmodule

bind ssf_status_top ssf_status_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  ssf_status_chk_inst (.*);

// File: testbench/sync_serial_status_flags_test.sv
/*
  Bench for the status block: bus tasks, one task per scenario,
  engine model on the strobes. Assumes a 25 MHz core clock.
*/
`timescale 1ns/1ps
module sync_serial_status_flags_test;
  import ssf_pkg::*;
  // Model request bits
  localparam logic [10:0] E_ST = 11'h001, E_SP = 11'h002,
    E_AD = 11'h004, E_DD = 11'h008, E_MT = 11'h010, E_RX = 11'h020,
    E_TL = 11'h040, E_TD = 11'h080, E_BR = 11'h100, E_UR = 11'h200,
    E_UC = 11'h400;
  logic        core_clk;   // Core clock
  logic        rst_n;      // Reset
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [10:0] req;        // Request to model
  logic [10:0] strb;       // Model strobes
  logic        rw_in;      // R/W to model
  logic        rw_out;     // R/W from model
  logic        irq;        // Interrupt
  logic        ten_bit;    // Ten-bit mode level
  logic [31:0] q;          // Read result
  int          mismatches;
  int          num_checks;
  ssf_status_top ssf_status_top_inst (.core_clk(core_clk),
    .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .start_det(strb[0]),
    .stop_det(strb[1]), .addr_byte_done(strb[2]),
    .data_byte_done(strb[3]), .addr_match(strb[4]),
    .match_rw(rw_out), .rx_complete(strb[5]), .tx_load(strb[6]),
    .tx_done(strb[7]), .buffer_read(strb[8]),
    .addr_update_req(strb[9]), .addr_reg_written(strb[10]),
    .port_enable_control(), .i2c_mode(), .ten_bit_mode(ten_bit),
    .irq(irq));
  ssf_eng_model ssf_eng_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .req(req), .rw_in(rw_in), .strb(strb), .rw_out(rw_out));
  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer; held until waitrequest is seen low at an edge.
  // Values read just after the edge are those the slave showed at it,
  // so read data is taken at the very edge where waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic st(input logic [7:0] e);
    rd(SSF_OFF_STATUS, {24'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // One engine event, R/W bit beside it
  task automatic pulse(input logic [10:0] v, input logic rw = 1'b0);
    @(posedge core_clk);
    req   <= v;
    rw_in <= rw;
    @(posedge core_clk);
    req   <= '0;
  endtask
  task automatic cirq(input logic e);
    @(negedge core_clk);
    chk(irq, e);
  endtask
  task automatic t_reset;
    st(8'h00);
    rd(SSF_OFF_CTRL, 32'h0);
    rd(8'h00, 32'h0);
  endtask
  task automatic t_i2c;
    wr(SSF_OFF_CTRL, 32'h3);
    pulse(E_ST); st(8'h08);
    pulse(E_MT, 1'b1); st(8'h0c);
    pulse(E_AD); st(8'h0c);
    pulse(E_DD); st(8'h2c);
    pulse(E_ST); st(8'h28);
    pulse(E_SP); st(8'h30);
    pulse(E_ST | E_SP); st(8'h30);
    pulse(E_AD); st(8'h10);
    wr(SSF_OFF_STATUS, 32'hff); st(8'h10);
  endtask
  task automatic t_buf;
    pulse(E_RX); st(8'h11);
    pulse(E_BR); st(8'h10);
    pulse(E_TL); st(8'h11);
    pulse(E_TD); st(8'h10);
    pulse(E_RX | E_BR); st(8'h11);
    pulse(E_BR); st(8'h10);
  endtask
  task automatic t_ua;
    pulse(E_UR); st(8'h10);
    wr(SSF_OFF_CTRL, 32'h7);
    pulse(E_UR); st(8'h12);
    chk(ten_bit, 1'b1);
    pulse(E_UC); st(8'h10);
  endtask
  task automatic t_off;
    pulse(E_ST | E_RX); st(8'h09);
    wr(SSF_OFF_CTRL, 32'h0); st(8'h01);
    pulse(E_ST); st(8'h01);
  endtask
  task automatic t_spi;
    wr(SSF_OFF_CTRL, 32'h1);
    pulse(E_ST | E_TD); st(8'h01);
    pulse(E_BR); st(8'h00);
    pulse(E_TL | E_MT, 1'b1); st(8'h00);
    pulse(E_RX); st(8'h01);
  endtask
  task automatic t_irq;
    wr(SSF_OFF_CTRL, 32'h3);
    wr(SSF_OFF_IRQ_STAT, 32'hf);
    wr(SSF_OFF_IRQ_MASK, 32'h1);
    rd(SSF_OFF_IRQ_STAT, 32'h0);
    cirq(1'b0);
    pulse(E_ST); rd(SSF_OFF_IRQ_STAT, 32'h1);
    cirq(1'b1);
    wr(SSF_OFF_IRQ_STAT, 32'h1); cirq(1'b0);
    pulse(E_SP); rd(SSF_OFF_IRQ_STAT, 32'h2);
    cirq(1'b0);
    wr(SSF_OFF_IRQ_MASK, 32'h2); cirq(1'b1);
    rd(SSF_OFF_IRQ_MASK, 32'h2);
    wr(SSF_OFF_IRQ_STAT, 32'h2); cirq(1'b0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; req = '0; rw_in = 1'b0;
    mismatches = 0; num_checks = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset; t_i2c; t_buf; t_ua; t_off; t_spi; t_irq;
    stop_test;
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    stop_test;
  end
endmodule
